// >>> src/qdf_quad_dual_fifo.sv
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
module qdf_quad_dual_fifo #(
	parameter int DEPTH_LOG2 = qdf_pkg::DEPTH_LOG2
) (
	input  logic                 core_clk,
	input  logic                 arst_n,
	input  logic                 clkEn,
	input  qdf_pkg::qdf_pins_t   pinIn,
	input  qdf_pkg::qdf_bus_req_t regReq,
	output logic [31:0]          regRdata,
	output qdf_pkg::qdf_flags_t  flagsOut,
	output logic [qdf_pkg::NUM_FIFO-1:0][qdf_pkg::ENTRY_W-1:0] dataOut,
	output logic                 irq
);
	import qdf_pkg::*;

	localparam int               DEPTH     = 1 << DEPTH_LOG2;
	localparam logic [DEPTH_LOG2:0] DEPTH_CNT = (DEPTH_LOG2+1)'(DEPTH);

	// State of the block, all but the word storage
	typedef struct packed {
		qdf_pins_t                              s1;        // First sync stage
		qdf_pins_t                              s2;        // Second sync stage
		logic [NUM_FIFO-1:0]                    prevWc;    // Write clock history
		logic [NUM_FIFO-1:0]                    prevRc;    // Read clock history
		logic                                   prevSc;    // Serial clock history
		logic                                   quad;      // Four FIFOs
		logic                                   first_word_fall_through;      // Fall-through mode
		logic                                   wide;      // x20 write bus
		logic [1:0]                             fsel;      // Latched offset code
		logic [OFF_W-1:0]                       aeOff;     // Almost empty offset
		logic [OFF_W-1:0]                       afOff;     // Almost full offset
		logic [NUM_FIFO-1:0][DEPTH_LOG2-1:0]    wp;        // Write pointers
		logic [NUM_FIFO-1:0][DEPTH_LOG2-1:0]    rp;        // Read pointers
		logic [NUM_FIFO-1:0][DEPTH_LOG2:0]      cnt;       // Words in memory
		logic [NUM_FIFO-1:0]                    outValid;  // Output word held
		logic [NUM_FIFO-1:0]                    echoClk;   // Echo clocks
		logic [NUM_FIFO-1:0]                    echoStb;   // Echo strobes
		logic [NUM_FIFO-1:0][ENTRY_W-1:0]       dout;      // Output words
		logic [STAT_W-1:0]                      stat;      // Sticky events
		logic [STAT_W-1:0]                      mask;      // Interrupt mask
		logic [31:0]                            rdata;     // Read data
	} qdf_state_t;

	qdf_state_t                        st;        // Current state
	qdf_state_t                        nx;        // Next state
	logic [NUM_FIFO-1:0][ENTRY_W-1:0]  laneIn;    // Routed write words
	logic [NUM_FIFO-1:0][ENTRY_W-1:0]  memQ;      // Word at read pointer
	logic [NUM_FIFO-1:0]               wrEdge;    // Write clock rose
	logic [NUM_FIFO-1:0]               rdEdge;    // Read clock rose
	logic [NUM_FIFO-1:0]               act;       // FIFO in use
	logic [NUM_FIFO-1:0]               wrFire;    // Word stored
	logic [NUM_FIFO-1:0]               rdReq;     // Read requested
	logic [NUM_FIFO-1:0]               rdFire;    // Word popped
	logic [NUM_FIFO-1:0]               readNew;   // Read gave a new word
	logic                              mrActive;  // Master reset held
	logic                              serShift;  // Serial bit taken
	logic [STAT_W-1:0]                 ev;        // Event pulses

	// Default offset decode
	function automatic logic [OFF_W-1:0] defaultOffset(input logic [1:0] sel);
		logic [OFF_W-1:0] v;
		v = OFFSET_SEL0;
		unique case (sel)
			2'h0: v = OFFSET_SEL0;
			2'h1: v = OFFSET_SEL1;
			2'h2: v = OFFSET_SEL2;
			2'h3: v = OFFSET_SEL3;
		endcase
		return v;
	endfunction : defaultOffset

	////////////////////////////////////////////////////////////////////////
	// Per FIFO lanes and storage
	for (genvar g = 0; g < NUM_FIFO; g++) begin : gFifo
		logic [ENTRY_W-1:0] mem [DEPTH];  // Word storage
		logic [ENTRY_W-1:0] dualWord;     // Twenty-bit lane

		assign dualWord = st.s2.dataIn[(g/2)*ENTRY_W +: ENTRY_W];
		assign laneIn[g] = st.quad ?
			{{(ENTRY_W-LANE_W){1'b0}}, st.s2.dataIn[g*LANE_W +: LANE_W]} :
			st.wide ? dualWord : {{(ENTRY_W-LANE_W){1'b0}}, dualWord[LANE_W-1:0]};
		assign memQ[g] = mem[st.rp[g]];

		// Storage write, frozen with the clock enable
		always_ff @(posedge core_clk) begin
			if (clkEn && wrFire[g]) begin
				mem[st.wp[g]] <= laneIn[g];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Strobes and flags from the current state
	always_comb begin
		mrActive = !st.s2.fullDeviceResetN;
		serShift = !mrActive && st.s2.serialClk && !st.prevSc && !st.s2.serialWrEnN;
		flagsOut = '0;
		ev       = '0;
		for (int i = 0; i < NUM_FIFO; i++) begin
			act[i]    = st.quad || (i % 2 == 0);
			wrEdge[i] = st.s2.wrClk[i] && !st.prevWc[i];
			rdEdge[i] = st.s2.rdClk[i] && !st.prevRc[i];
			wrFire[i] = !mrActive && act[i] && wrEdge[i] && !st.s2.wrEnN[i]
				&& (st.cnt[i] != DEPTH_CNT);
			rdReq[i]  = !mrActive && act[i] && rdEdge[i] && !st.s2.rdEnN[i];
			if (st.first_word_fall_through) begin
				// Prefetch whenever the output word is free
				rdFire[i]  = (st.cnt[i] != '0) && (!st.outValid[i] || rdReq[i]);
				readNew[i] = rdReq[i] && st.outValid[i] && (st.cnt[i] != '0);
				ev[NUM_FIFO+i] = rdReq[i] && !st.outValid[i];
			end else begin
				rdFire[i]  = rdReq[i] && (st.cnt[i] != '0);
				readNew[i] = rdFire[i];
				ev[NUM_FIFO+i] = rdReq[i] && (st.cnt[i] == '0);
			end
			// Write attempt while full
			ev[i] = !mrActive && act[i] && wrEdge[i] && !st.s2.wrEnN[i]
				&& (st.cnt[i] == DEPTH_CNT);
			flagsOut.emptyOrReady[i] = st.first_word_fall_through ? st.outValid[i] : (st.cnt[i] == '0);
			flagsOut.fullOrReady[i]  = st.first_word_fall_through ? (st.cnt[i] != DEPTH_CNT)
				: (st.cnt[i] == DEPTH_CNT);
			flagsOut.almostEmpty[i]  = st.cnt[i] <= (DEPTH_LOG2+1)'(st.aeOff);
			flagsOut.almostFull[i]   = st.cnt[i] >= DEPTH_CNT - (DEPTH_LOG2+1)'(st.afOff);
		end
		flagsOut.echoReadClock  = st.echoClk;
		flagsOut.echoReadStrobe = st.echoStb;
	end

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic [STAT_W-1:0] clr;  // Write-one-to-clear bits
		clr       = '0;
		nx        = st;
		nx.s1     = pinIn;
		nx.s2     = st.s1;
		nx.prevWc = st.s2.wrClk;
		nx.prevRc = st.s2.rdClk;
		nx.prevSc = st.s2.serialClk;
		// echo lags data by a cycle
		nx.echoClk = st.prevRc;
		if (mrActive) begin
			nx.quad  = st.s2.quadDualSelect;
			nx.first_word_fall_through  = st.s2.fallThroughOrSerialIn;
			nx.wide  = !st.s2.quadDualSelect && st.s2.writeWidthSelect;
			nx.fsel  = st.s2.defaultOffsetSelect;
			nx.aeOff = defaultOffset(st.s2.defaultOffsetSelect);
			nx.afOff = defaultOffset(st.s2.defaultOffsetSelect);
			nx.wp       = '0;
			nx.rp       = '0;
			nx.cnt      = '0;
			nx.outValid = '0;
			nx.dout     = '0;
			nx.echoStb  = '0;
		end else begin
			if (serShift) begin
				{nx.aeOff, nx.afOff} = {st.aeOff[OFF_W-2:0], st.afOff,
					st.s2.fallThroughOrSerialIn};
			end
			for (int i = 0; i < NUM_FIFO; i++) begin
				nx.wp[i]  = st.wp[i] + DEPTH_LOG2'(wrFire[i]);
				nx.rp[i]  = st.rp[i] + DEPTH_LOG2'(rdFire[i]);
				nx.cnt[i] = st.cnt[i] + (DEPTH_LOG2+1)'(wrFire[i])
					- (DEPTH_LOG2+1)'(rdFire[i]);
				if (rdFire[i]) begin
					nx.dout[i]     = memQ[i];
					nx.outValid[i] = 1'b1;
				end else if (rdReq[i]) begin
					nx.outValid[i] = 1'b0;
				end
				if (rdEdge[i]) begin
					nx.echoStb[i] = readNew[i];
				end
			end
		end
		// Register writes, set wins over clear
		clr = (regReq.wr && regReq.addr == REG_STATUS) ? regReq.wdata[STAT_W-1:0] : '0;
		nx.stat = (st.stat & ~clr) | ev;
		if (regReq.wr && regReq.addr == REG_MASK) begin
			nx.mask = regReq.wdata[STAT_W-1:0];
		end
		// Register reads, zero when idle or unmapped
		nx.rdata = '0;
		if (regReq.rd) begin
			unique case (regReq.addr)
				REG_STATUS: nx.rdata = {{(32-STAT_W){1'b0}}, st.stat};
				REG_MASK:   nx.rdata = {{(32-STAT_W){1'b0}}, st.mask};
				REG_CONFIG: nx.rdata = {27'h0, st.fsel, st.wide, st.first_word_fall_through, st.quad};
				REG_OFFSET: nx.rdata = {6'h0, st.afOff, 6'h0, st.aeOff};
				default:    nx.rdata = '0;
			endcase
		end
	end

	// State register, frozen while the enable is low
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st      <= '0;
			st.s1.fullDeviceResetN <= 1'b0;
			st.s2.fullDeviceResetN <= 1'b0;
			st.aeOff <= OFFSET_SEL0;
			st.afOff <= OFFSET_SEL0;
			st.stat  <= STATUS_RST;
			st.mask  <= MASK_RST;
		end else if (clkEn) begin
			st <= nx;
		end
	end

	// Outputs
	assign dataOut  = st.dout;
	assign regRdata = st.rdata;
	assign irq      = |(st.stat & st.mask);

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n || !clkEn);

	sequence seqRdEdge0;
		rdEdge[0] ##1 st.prevRc[0];
	endsequence
	sequence seqNewWord0;
		rdEdge[0] && readNew[0];
	endsequence

	AST_QUAD_LANE: assert property (st.quad |-> laneIn[3][LANE_W-1:0]
		== st.s2.dataIn[39:30] && laneIn[1][ENTRY_W-1:LANE_W] == '0)
		else $error("quad lane routing wrong");
	AST_DUAL_LANE: assert property (!st.quad && st.wide |->
		laneIn[0] == st.s2.dataIn[19:0] && laneIn[2] == st.s2.dataIn[39:20])
		else $error("dual lane routing wrong");
	AST_OWN_WRITE: assert property (wrFire[1] |-> !st.s2.wrEnN[1]
		##1 st.wp[1] == $past(st.wp[1]) + 1'b1)
		else $error("write not on own port");
	AST_EMPTY_MODE: assert property (flagsOut.emptyOrReady[0] ==
		(st.first_word_fall_through ? st.outValid[0] : st.cnt[0] == '0))
		else $error("read flag meaning wrong");
	AST_FULL_MODE: assert property (st.first_word_fall_through |->
		flagsOut.fullOrReady[2] != (st.cnt[2] == DEPTH_CNT))
		else $error("input ready wrong");
	AST_ECHO_LAG: assert property (seqRdEdge0 |=> st.echoClk[0])
		else $error("echo clock not following");
	AST_ECHO_STB: assert property (seqNewWord0 |=>
		st.echoStb[0] && st.dout[0] == $past(memQ[0]))
		else $error("echo strobe missing");
	AST_OFFS_DEF: assert property (mrActive |=> st.aeOff == st.afOff &&
		st.aeOff == defaultOffset($past(st.s2.defaultOffsetSelect)))
		else $error("default offset wrong");
	AST_MODE_LATCH: assert property (mrActive |=>
		st.first_word_fall_through == $past(st.s2.fallThroughOrSerialIn) && st.quad == $past(st.s2.quadDualSelect))
		else $error("mode not latched");
	AST_SERIAL_IN: assert property (serShift |=>
		st.afOff[0] == $past(st.s2.fallThroughOrSerialIn))
		else $error("serial bit lost");
	AST_QUAD_WIDTH: assert property (st.quad |-> !st.wide)
		else $error("quad width not ten");
	AST_PTR_RESET: assert property (mrActive |=> st.cnt == '0 && st.wp == '0)
		else $error("pointers not cleared");
	AST_CFG_HOLD: assert property (!mrActive |=>
		$stable({st.quad, st.first_word_fall_through, st.wide, st.fsel}))
		else $error("configuration changed");

endmodule : qdf_quad_dual_fifo

// >>> src/qdf_pkg.sv
package qdf_pkg;

	////////////////////////////////////////////////////////////////////////
	// Sizes
	localparam int NUM_FIFO   = 4;   // Internal FIFO instances
	localparam int IN_W       = 40;  // Shared write data bus
	localparam int LANE_W     = 10;  // Narrow lane width
	localparam int ENTRY_W    = 20;  // Stored word, wide enough for x20
	localparam int OFF_W      = 10;  // Almost flag offset width
	localparam int DEPTH_LOG2 = 15;  // Words per FIFO, as a power of two
	localparam int STAT_W     = 8;   // Event bits

	////////////////////////////////////////////////////////////////////////
	// Default flag offsets, picked by the two offset select pins
	localparam logic [OFF_W-1:0] OFFSET_SEL0 = 10'h007;
	localparam logic [OFF_W-1:0] OFFSET_SEL1 = 10'h03f;
	localparam logic [OFF_W-1:0] OFFSET_SEL2 = 10'h07f;
	localparam logic [OFF_W-1:0] OFFSET_SEL3 = 10'h3ff;

	////////////////////////////////////////////////////////////////////////
	// Register map and reset values
	localparam logic [7:0]        REG_STATUS = 8'h00;  // Sticky events, write one clears
	localparam logic [7:0]        REG_MASK   = 8'h04;  // Interrupt mask
	localparam logic [7:0]        REG_CONFIG = 8'h08;  // Latched configuration
	localparam logic [7:0]        REG_OFFSET = 8'h0c;  // Almost flag offsets
	localparam logic [STAT_W-1:0] STATUS_RST = 8'h00;
	localparam logic [STAT_W-1:0] MASK_RST   = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic [IN_W-1:0]     dataIn;                // Write data lanes
		logic [NUM_FIFO-1:0] wrClk;                 // Per FIFO write clock
		logic [NUM_FIFO-1:0] wrEnN;                 // Per FIFO write enable
		logic [NUM_FIFO-1:0] rdClk;                 // Per FIFO read clock
		logic [NUM_FIFO-1:0] rdEnN;                 // Per FIFO read enable
		logic                fullDeviceResetN;      // Master reset pin
		logic                quadDualSelect;        // High four FIFOs
		logic                writeWidthSelect;      // High x20 in dual
		logic [1:0]          defaultOffsetSelect;   // Default offset code
		logic                fallThroughOrSerialIn; // Mode strap, then serial data
		logic                serialClk;             // Serial offset clock
		logic                serialWrEnN;           // Serial write enable
	} qdf_pins_t;

	typedef struct packed {
		logic [NUM_FIFO-1:0] emptyOrReady;    // Empty, or output ready
		logic [NUM_FIFO-1:0] fullOrReady;     // Full, or input ready
		logic [NUM_FIFO-1:0] almostEmpty;     // Level at or under offset
		logic [NUM_FIFO-1:0] almostFull;      // Free space at or under offset
		logic [NUM_FIFO-1:0] echoReadClock;   // Lags the read clock
		logic [NUM_FIFO-1:0] echoReadStrobe;  // New word after a read
	} qdf_flags_t;

	typedef struct packed {
		logic [7:0]  addr;   // Byte address
		logic [31:0] wdata;  // Write data
		logic        wr;     // Write strobe
		logic        rd;     // Read strobe
	} qdf_bus_req_t;

endpackage : qdf_pkg

// >>> test/qdf_port_partner.sv
`timescale 1ns/100ps
// Writer and reader logic on the far side of the FIFO ports
module qdf_port_partner (
	output logic [qdf_pkg::IN_W-1:0]     dataIn,
	output logic [qdf_pkg::NUM_FIFO-1:0] wrClk,
	output logic [qdf_pkg::NUM_FIFO-1:0] wrEnN,
	output logic [qdf_pkg::NUM_FIFO-1:0] rdClk,
	output logic [qdf_pkg::NUM_FIFO-1:0] rdEnN
);
	import qdf_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Port clocks stand low between frames, enables off
	initial begin
		dataIn = '0;
		wrClk  = '0;
		wrEnN  = '1;
		rdClk  = '0;
		rdEnN  = '1;
	end

	////////////////////////////////////////////////////////////////////////
	// One write frame, 160 ns port clock, off the core clock phase
	task automatic put_word(
		input logic [1:0]  idx,
		input logic [19:0] word,
		input logic        narrow
	);
		logic [59:0] lane;
		logic [59:0] keep;
		keep = 60'(narrow ? 20'h003ff : 20'hfffff) << (idx * 10);
		lane = 60'(word) << (idx * 10);
		#3;
		dataIn     = lane[39:0] & keep[39:0];
		wrEnN[idx] = 1'b0;
		#80;
		wrClk[idx] = 1'b1;
		#80;
		wrClk[idx] = 1'b0;
		wrEnN[idx] = 1'b1;
		// Hold over, lane shows the inverse
		dataIn     = ~lane[39:0] & keep[39:0];
		#80;
	endtask : put_word

	////////////////////////////////////////////////////////////////////////
	// One read frame on the chosen read port
	task automatic take_word(input logic [1:0] idx);
		#3;
		rdEnN[idx] = 1'b0;
		#80;
		rdClk[idx] = 1'b1;
		#80;
		rdClk[idx] = 1'b0;
		rdEnN[idx] = 1'b1;
		#80;
	endtask : take_word

endmodule : qdf_port_partner

// >>> test/qdf_quad_dual_fifo_bench.sv
`timescale 1ns/100ps
// Self-checking bench for the quad/dual FIFO block
module qdf_quad_dual_fifo_bench;
	import qdf_pkg::*;

	typedef struct packed {
		logic       quad;
		logic       wide;
		logic       first_word_fall_through;
		logic [1:0] fsel;
		logic [9:0] off;   // Default offset expected
	} qdf_row_t;

	localparam int DLOG = 4;      // 16 word FIFOs
	localparam int CEIL = 20000;  // Hang limit in cycles
	logic                             core_clk = 1'b0;
	logic                             arst_n   = 1'b0;
	logic                             clkEn    = 1'b1;
	qdf_pins_t                        pinIn;
	qdf_bus_req_t                     regReq   = '0;
	logic [31:0]                      regRdata;
	qdf_flags_t                       flagsOut;
	logic [NUM_FIFO-1:0][ENTRY_W-1:0] dataOut;
	logic                             irq;
	logic [IN_W-1:0]                  dIn;
	logic [NUM_FIFO-1:0]              wc, we, rc, re;
	logic mrN = 1'b0, quad = 1'b1, wide = 1'b0, first_word_fall_through = 1'b0, sClk = 1'b0, sWrN = 1'b1;
	logic [1:0]                       fsel = 2'b00;
	logic [31:0]                      rd;
	logic [19:0]                      word, msk;
	int numErrors = 0, testsRun = 0, cycles = 0;
	qdf_row_t rows [4] = '{'{1'b1, 1'b0, 1'b0, 2'b00, 10'h007}, '{1'b0, 1'b1, 1'b1, 2'b01, 10'h03f},
		'{1'b0, 1'b0, 1'b0, 2'b10, 10'h07f}, '{1'b1, 1'b1, 1'b1, 2'b11, 10'h3ff}};

	assign pinIn = {dIn, wc, we, rc, re, mrN, quad, wide, fsel, first_word_fall_through, sClk, sWrN};

	qdf_quad_dual_fifo #(.DEPTH_LOG2(DLOG)) i_dut (.core_clk(core_clk), .arst_n(arst_n),
		.clkEn(clkEn), .pinIn(pinIn), .regReq(regReq), .regRdata(regRdata),
		.flagsOut(flagsOut), .dataOut(dataOut), .irq(irq));
	qdf_port_partner i_partner (.dataIn(dIn), .wrClk(wc), .wrEnN(we), .rdClk(rc), .rdEnN(re));

	////////////////////////////////////////////////////////////////////////
	// Clock and hang limit
	always #10 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == CEIL) begin
			numErrors++;
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Compare, verdict, bus and strap tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		testsRun++;
		if (got !== exp) begin
			numErrors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : check
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", testsRun, numErrors);
		if (numErrors == 0 && testsRun > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : give_verdict
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		regReq.wr <= 1'b0;
		// Step off the edge so callers see the written state
		#1;
	endtask : reg_wr
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		regReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		regReq.rd <= 1'b0;
		#1 d = regRdata;
	endtask : reg_rd
	task automatic mreset(input qdf_row_t r);
		@(posedge core_clk);
		mrN  <= 1'b0;
		quad <= r.quad;
		wide <= r.wide;
		first_word_fall_through <= r.first_word_fall_through;
		fsel <= r.fsel;
		repeat (5) @(posedge core_clk);
		mrN <= 1'b1;
		repeat (8) @(posedge core_clk);
	endtask : mreset

	////////////////////////////////////////////////////////////////////////
	// Main sequence: table of strap settings, then the awkward cases
	initial begin
		repeat (5) @(posedge core_clk);
		arst_n <= 1'b1;
		foreach (rows[r]) begin
			mreset(rows[r]);
			reg_rd(REG_CONFIG, rd);
			// Layout {fsel, wide, first_word_fall_through, quad}; wide only counts in dual mode
			word = 20'({rows[r].fsel, rows[r].wide & ~rows[r].quad, rows[r].first_word_fall_through, rows[r].quad});
			check(rd, 32'(word), "config");
			reg_rd(REG_OFFSET, rd);
			check(rd, {6'h0, rows[r].off, 6'h0, rows[r].off}, "offsets");
			msk = (rows[r].quad || !rows[r].wide) ? 20'h003ff : 20'hfffff;
			for (int i = 0; i < 4; i++) begin
				if (!rows[r].quad && i[0]) continue;
				word = (20'h9c3a5 + 20'(i * 20'h11111)) & msk;
				i_partner.put_word(2'(i), word, msk[10] == 1'b0);
				check(flagsOut.emptyOrReady[i], rows[r].first_word_fall_through, "read flag");
				check(flagsOut.fullOrReady[i], rows[r].first_word_fall_through, "write flag");
				check(flagsOut.almostEmpty[i], 1'b1, "almost empty");
				if (rows[r].first_word_fall_through) check(dataOut[i] & msk, word, "fall-through word");
				i_partner.take_word(2'(i));
				if (!rows[r].first_word_fall_through) check(dataOut[i] & msk, word, "read word");
				if (!rows[r].first_word_fall_through) check(flagsOut.echoReadStrobe[i], 1'b1, "echo strobe");
				// Echo clock follows the idle read clock back down
				check(flagsOut.echoReadClock[i], 1'b0, "echo clock low");
				check(flagsOut.emptyOrReady[i], !rows[r].first_word_fall_through, "read flag drained");
			end
		end
		// Fill FIFO 0 past full, interrupt raised, masked, cleared
		mreset(rows[0]);
		reg_wr(REG_MASK, 32'h1);
		for (int k = 0; k < 16; k++) begin
			// Words start at one, so a cleared output cannot pass for the first
			i_partner.put_word(2'd0, 20'(k + 1), 1'b1);
			check(flagsOut.almostFull[0], k >= 8, "almost full edge");
		end
		check(flagsOut.fullOrReady[0], 1'b1, "full");
		check(irq, 1'b0, "no irq yet");
		i_partner.put_word(2'd0, 20'h3ff, 1'b1);
		i_partner.take_word(2'd1);
		check(irq, 1'b1, "irq on overflow");
		reg_rd(REG_STATUS, rd);
		check(rd, 32'h21, "sticky events");
		reg_wr(REG_MASK, 32'h0);
		check(irq, 1'b0, "irq masked");
		reg_wr(REG_STATUS, 32'h21);
		reg_wr(REG_MASK, 32'h1);
		check(irq, 1'b0, "irq cleared");
		i_partner.take_word(2'd0);
		check(dataOut[0], 20'h1, "first word first");
		// Serial offsets load after reset, straps moved without reset
		quad <= 1'b0;
		fsel <= 2'b11;
		for (int b = 19; b >= 0; b--) begin
			@(posedge core_clk);
			first_word_fall_through <= b[0] ^ b[2];
			sWrN <= 1'b0;
			repeat (4) @(posedge core_clk);
			sClk <= 1'b1;
			repeat (4) @(posedge core_clk);
			sClk <= 1'b0;
		end
		sWrN <= 1'b1;
		reg_rd(REG_OFFSET, rd);
		// First bit lands in the top of the almost empty offset
		check(rd, {6'h0, 10'h25a, 6'h0, 10'h296}, "serial offsets");
		reg_wr(REG_CONFIG, 32'h1e);
		reg_rd(REG_CONFIG, rd);
		check(rd, 32'h01, "config held");
		reg_rd(8'h10, rd);
		check(rd, 32'h0, "unmapped read");
		// Reset in mid-run clears read data, leaves flags showing empty
		@(posedge core_clk);
		arst_n <= 1'b0;
		// Standard mode and empty: only empty and almost empty stand
		#5 check(32'(flagsOut), 32'hf0f000, "flags in reset");
		check(regRdata, 32'h0, "read data in reset");
		give_verdict();
	end

endmodule : qdf_quad_dual_fifo_bench
